// ==== aic_clkdiv.sv ====
// Conversion clock tick generator: one-cycle tick every 2**sel system clocks.
// Assumes the tick enable is held while a conversion runs.
`timescale 1ns/10ps
module aic_clkdiv
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic [6:0] limit;

    always_comb
    begin
        limit    = 7'((8'h01 << sel) - 8'h01);
        cnt_next = 7'h00;
        tick     = 1'b0;
        if (run)
        begin
            if (cnt_reg >= limit)
            begin
                tick     = 1'b1;
            end
            else
            begin
                cnt_next = 7'(cnt_reg + 7'h01);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 7'h00;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : aic_clkdiv

// ==== aic_ctrl.sv ====
// Converter input select and conversion control with AHB-Lite registers.
// Assumes a single system clock and an analog core that delivers its
// 12-bit result on DATA_IN by the end of the conversion window.
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module aic_ctrl
#(
    parameter int           CHAN_COUNT = 16
)
(
    input  wire logic                   CLK_SYS,
    input  wire logic                   RSTN,
    input  wire logic                   HSEL,
    input  wire logic [31:0]            HADDR,
    input  wire logic [1:0]             HTRANS,
    input  wire logic                   HWRITE,
    input  wire logic [2:0]             HSIZE,
    input  wire logic [31:0]            HWDATA,
    input  wire logic                   HREADY,
    output logic [31:0]                 HRDATA,
    output logic                        HREADYOUT,
    output logic                        HRESP,
    input  wire logic [11:0]            DATA_IN,
    output aic_pkg::aic_afe_t           AFE,
    output aic_pkg::aic_pin_t           PIN_CTRL,
    output logic                        IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    typedef enum logic [2:0] {
        AIC_IDLE   = 3'b001,
        AIC_SAMPLE = 3'b010,
        AIC_CONV   = 3'b100
    } aic_state_t;

    logic [7:0]     ctrl0_reg;
    logic [7:0]     ctrl0_next;
    logic [7:0]     ctrl1_reg;
    logic [7:0]     ctrl1_next;
    logic [15:0]    pinsel_reg;
    logic [15:0]    pinsel_next;
    logic [11:0]    result_reg;
    logic [11:0]    result_next;
    logic           busy_reg;
    logic           busy_next;
    logic           armed_reg;
    logic           armed_next;
    logic           irq_stat_reg;
    logic           irq_stat_next;
    logic           irq_mask_reg;
    logic           irq_mask_next;
    aic_state_t     state_reg;
    aic_state_t     state_next;
    logic [4:0]     cyc_reg;
    logic [4:0]     cyc_next;
    logic           ph_valid_reg;
    logic           ph_valid_next;
    logic           ph_write_reg;
    logic           ph_write_next;
    logic [7:0]     ph_addr_reg;
    logic [7:0]     ph_addr_next;
    logic [31:0]    rdata_reg;
    logic [31:0]    rdata_next;

    logic           tick;
    logic           enable;
    logic           start_go;
    logic           done;
    logic [3:0]     src_code;
    logic [3:0]     chan_code;
    logic           wr_ctrl0;
    logic           rd_stat;

    // Decodes the source field into an internal source or external routing.
    function automatic aic_pkg::aic_src_t decode_src(input logic [3:0] code);
        aic_pkg::aic_src_t s;
        s = aic_pkg::AIC_SRC_EXT;
        if (code[3] && !code[2])
        begin
            s = aic_pkg::AIC_SRC_GND;
        end
        else if (!code[3] && code[1:0] != 2'b00)
        begin
            s = aic_pkg::aic_src_t'({code[2], code[1:0]} + 3'h0 - {2'b00, code[2]});
        end
        return s;
    endfunction : decode_src

    assign enable    = ctrl0_reg[aic_pkg::C0_ENABLE];
    assign src_code  = ctrl1_reg[aic_pkg::C1_SRC_LSB +: 4];
    assign chan_code = ctrl0_reg[3:0];
    assign done      = (state_reg == AIC_CONV) && tick
                       && (cyc_reg == aic_pkg::TOTAL_CYCLES - 5'h01);

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock divider.

    aic_clkdiv u_div
    (
        .clk   (CLK_SYS),
        .rst_n (RSTN),
        .run   (state_reg != AIC_IDLE),
        .sel   (ctrl1_reg[aic_pkg::C1_CKS_LSB +: 3]),
        .tick  (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY.

    always_comb
    begin
        ph_valid_next = HSEL && HREADY && HTRANS[1];
        ph_write_next = HWRITE;
        ph_addr_next  = HADDR[7:0];
        wr_ctrl0      = ph_valid_reg && ph_write_reg && ph_addr_reg == aic_pkg::CTRL0_OFF;
        rd_stat       = ph_valid_next && !HWRITE && HADDR[7:0] == aic_pkg::INT_STAT_OFF;
        rdata_next    = 32'h0000_0000;
        if (ph_valid_next && !HWRITE)
        begin
            unique case (HADDR[7:0])
                aic_pkg::CTRL0_OFF:
                    rdata_next = {24'h000000, ctrl0_reg[7], busy_reg, ctrl0_reg[5:0]};
                aic_pkg::CTRL1_OFF:
                    rdata_next = {24'h000000, ctrl1_reg[7:4], 1'b0, ctrl1_reg[2:0]};
                aic_pkg::RESULT_OFF:
                    rdata_next = ctrl0_reg[aic_pkg::C0_FORMAT]
                               ? {16'h0000, 4'h0, result_reg[11:8], result_reg[7:0]}
                               : {16'h0000, result_reg[11:4], result_reg[3:0], 4'h0};
                aic_pkg::PINSEL_OFF:
                    rdata_next = {16'h0000, pinsel_reg};
                aic_pkg::INT_STAT_OFF:
                    rdata_next = {31'h00000000, irq_stat_reg};
                aic_pkg::INT_MASK_OFF:
                    rdata_next = {31'h00000000, irq_mask_reg};
                default:
                    rdata_next = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers, start detection and conversion sequencing.

    always_comb
    begin
        ctrl0_next    = ctrl0_reg;
        ctrl1_next    = ctrl1_reg;
        pinsel_next   = pinsel_reg;
        irq_mask_next = irq_mask_reg;
        if (ph_valid_reg && ph_write_reg)
        begin
            unique case (ph_addr_reg)
                aic_pkg::CTRL0_OFF:    ctrl0_next    = HWDATA[7:0];
                aic_pkg::CTRL1_OFF:    ctrl1_next    = {HWDATA[7:4], 1'b0, HWDATA[2:0]};
                aic_pkg::PINSEL_OFF:   pinsel_next   = HWDATA[15:0];
                aic_pkg::INT_MASK_OFF: irq_mask_next = HWDATA[0];
                default:               ctrl0_next    = ctrl0_reg;
            endcase
        end

        // A low level arms, high then low again starts.
        armed_next = armed_reg;
        start_go   = 1'b0;
        if (wr_ctrl0)
        begin
            if (!HWDATA[aic_pkg::C0_START] && ctrl0_reg[aic_pkg::C0_START] && armed_reg)
            begin
                start_go   = enable && HWDATA[aic_pkg::C0_ENABLE];
                armed_next = 1'b1;
            end
            else if (!HWDATA[aic_pkg::C0_START])
            begin
                armed_next = 1'b1;
            end
        end

        state_next  = state_reg;
        cyc_next    = cyc_reg;
        busy_next   = busy_reg;
        result_next = result_reg;
        unique case (state_reg)
            AIC_IDLE:
                if (start_go && !busy_reg)
                begin
                    state_next = AIC_SAMPLE;
                    cyc_next   = 5'h00;
                    busy_next  = 1'b1;
                end
            AIC_SAMPLE:
                if (tick)
                begin
                    cyc_next = 5'(cyc_reg + 5'h01);
                    if (cyc_reg == aic_pkg::SAMPLE_CYCLES - 5'h01)
                    begin
                        state_next = AIC_CONV;
                    end
                end
            AIC_CONV:
                if (tick)
                begin
                    cyc_next = 5'(cyc_reg + 5'h01);
                    if (done)
                    begin
                        state_next  = AIC_IDLE;
                        busy_next   = 1'b0;
                        result_next = DATA_IN;
                    end
                end
        endcase
        if (!enable)
        begin
            state_next  = AIC_IDLE;
            busy_next   = 1'b0;
            result_next = result_reg;
        end

        irq_stat_next = rd_stat ? 1'b0 : irq_stat_reg;
        if (done && enable)
        begin
            irq_stat_next = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ctrl0_reg    <= aic_pkg::CTRL0_RST;
            ctrl1_reg    <= aic_pkg::CTRL1_RST;
            pinsel_reg   <= aic_pkg::PINSEL_RST;
            result_reg   <= 12'h000;
            busy_reg     <= 1'b0;
            armed_reg    <= 1'b0;
            irq_stat_reg <= 1'b0;
            irq_mask_reg <= 1'b0;
            state_reg    <= AIC_IDLE;
            cyc_reg      <= 5'h00;
            ph_valid_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_addr_reg  <= 8'h00;
            rdata_reg    <= 32'h0000_0000;
        end
        else
        begin
            ctrl0_reg    <= ctrl0_next;
            ctrl1_reg    <= ctrl1_next;
            pinsel_reg   <= pinsel_next;
            result_reg   <= result_next;
            busy_reg     <= busy_next;
            armed_reg    <= armed_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            state_reg    <= state_next;
            cyc_reg      <= cyc_next;
            ph_valid_reg <= ph_valid_next;
            ph_write_reg <= ph_write_next;
            ph_addr_reg  <= ph_addr_next;
            rdata_reg    <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog routing and pin overrides.

    always_comb
    begin
        AFE            = '0;
        AFE.conv_power = enable;
        AFE.source     = decode_src(src_code);
        // Clearing enable drops both phases at once, a cycle before the state idles.
        AFE.sample     = enable && state_reg == AIC_SAMPLE;
        AFE.convert    = enable && state_reg == AIC_CONV;
        if (enable && AFE.source == aic_pkg::AIC_SRC_EXT && 32'(chan_code) < CHAN_COUNT)
        begin
            AFE.chan_connect[chan_code] = 1'b1;
        end
        PIN_CTRL.digital_disable = pinsel_reg;
        PIN_CTRL.pullup_disable  = pinsel_reg;
        PIN_CTRL.dir_force_input = pinsel_reg;
    end

    assign HRDATA    = rdata_reg;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign IRQ       = irq_stat_reg && irq_mask_reg;

endmodule : aic_ctrl

// ==== aic_monitor.sv ====
// Assertion monitor for the converter input select and control block.
// Assumes it is bound to aic_ctrl and sees only that module's ports.
`timescale 1ns/10ps
module aic_monitor
#(
    parameter int CHAN_COUNT = 16
)
(
    input wire logic              CLK_SYS,
    input wire logic              RSTN,
    input wire logic              HSEL,
    input wire logic [31:0]       HADDR,
    input wire logic [1:0]        HTRANS,
    input wire logic              HWRITE,
    input wire logic [2:0]        HSIZE,
    input wire logic [31:0]       HWDATA,
    input wire logic              HREADY,
    input wire logic [31:0]       HRDATA,
    input wire logic              HREADYOUT,
    input wire logic              HRESP,
    input wire logic [11:0]       DATA_IN,
    input wire aic_pkg::aic_afe_t AFE,
    input wire aic_pkg::aic_pin_t PIN_CTRL,
    input wire logic              IRQ
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////
    a_pin_digital:
        assert property (HSEL && HREADY && HTRANS[1] && HWRITE
                         && HADDR[7:0] == aic_pkg::PINSEL_OFF ##1 1'b1
                         |=> PIN_CTRL.digital_disable == $past(HWDATA[15:0]))
        else $error("Digital disable does not follow the pin select write.");
    a_pin_dir:
        assert property (PIN_CTRL.dir_force_input == PIN_CTRL.digital_disable)
        else $error("Direction override differs from digital disable.");
    a_pin_pullup:
        assert property (PIN_CTRL.pullup_disable == PIN_CTRL.digital_disable)
        else $error("Pull-up release differs from digital disable.");
    a_int_disc:
        assert property (AFE.source != aic_pkg::AIC_SRC_EXT |-> AFE.chan_connect == '0)
        else $error("External channel connected with internal source.");
    a_ext_single:
        assert property ($onehot0(AFE.chan_connect))
        else $error("More than one external channel connected.");
    a_phase_excl:
        assert property (!(AFE.sample && AFE.convert))
        else $error("Sampling and converting at once.");
    a_samp_conv:
        assert property ($fell(AFE.sample) && AFE.conv_power |-> AFE.convert)
        else $error("Conversion phase did not follow sampling.");
    a_conv_prior:
        assert property ($rose(AFE.convert) |-> $past(AFE.sample))
        else $error("Conversion phase began without sampling.");
    a_samp_min:
        assert property ($rose(AFE.sample) |-> (AFE.sample || !AFE.conv_power)[*4])
        else $error("Sampling phase shorter than four cycles.");
    a_off_idle:
        assert property (!AFE.conv_power |-> !AFE.sample && !AFE.convert)
        else $error("Converter active while powered off.");
    a_bus_okay:
        assert property (HREADYOUT && !HRESP)
        else $error("Bus slave stalled or answered with an error.");
    c_conv_start: cover property ($rose(AFE.sample));
    c_conv_end: cover property ($fell(AFE.convert) && AFE.conv_power);
    c_irq: cover property ($rose(IRQ));
endmodule : aic_monitor

bind aic_ctrl aic_monitor #(.CHAN_COUNT(CHAN_COUNT)) u_aic_monitor
(
    .CLK_SYS, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY,
    .HRDATA, .HREADYOUT, .HRESP, .DATA_IN, .AFE, .PIN_CTRL, .IRQ
);

// ==== aic_pkg.sv ====
// Package for the converter input select and conversion control block.
// Assumes one system clock and AHB-Lite register access with 32-bit words.
package aic_pkg;

    // Register byte offsets.
    localparam logic [7:0]  CTRL0_OFF       = 8'h00;
    localparam logic [7:0]  CTRL1_OFF       = 8'h04;
    localparam logic [7:0]  RESULT_OFF      = 8'h08;
    localparam logic [7:0]  PINSEL_OFF      = 8'h0c;
    localparam logic [7:0]  INT_STAT_OFF    = 8'h10;
    localparam logic [7:0]  INT_MASK_OFF    = 8'h14;

    // Control register 0 field positions.
    localparam int          C0_START        = 7;
    localparam int          C0_BUSY         = 6;
    localparam int          C0_ENABLE       = 5;
    localparam int          C0_FORMAT       = 4;

    // Control register 1 field positions.
    localparam int          C1_SRC_LSB      = 4;
    localparam int          C1_CKS_LSB      = 0;

    // Reset values.
    localparam logic [7:0]  CTRL0_RST       = 8'h00;
    localparam logic [7:0]  CTRL1_RST       = 8'h00;
    localparam logic [15:0] PINSEL_RST      = 16'h0000;

    // Conversion timing in conversion-clock cycles.
    localparam logic [4:0]  SAMPLE_CYCLES   = 5'h04;
    localparam logic [4:0]  CONV_CYCLES     = 5'h0c;
    localparam logic [4:0]  TOTAL_CYCLES    = 5'h10;

    // Number of external channels and data width.
    localparam int          NUM_CHAN        = 16;
    localparam int          RES_BITS        = 12;

    // Analog source codes: external routing or an internal source.
    typedef enum logic [2:0] {
        AIC_SRC_EXT    = 3'h0,
        AIC_SRC_SUP    = 3'h1,
        AIC_SRC_SUP2   = 3'h2,
        AIC_SRC_SUP4   = 3'h3,
        AIC_SRC_AMP    = 3'h4,
        AIC_SRC_AMP2   = 3'h5,
        AIC_SRC_AMP4   = 3'h6,
        AIC_SRC_GND    = 3'h7
    } aic_src_t;

    // Routing to the analog front end.
    typedef struct packed {
        logic                   conv_power;
        aic_src_t               source;
        logic [NUM_CHAN-1:0]    chan_connect;
        logic                   sample;
        logic                   convert;
    } aic_afe_t;

    // Pin override toward the port logic.
    typedef struct packed {
        logic [NUM_CHAN-1:0]    digital_disable;
        logic [NUM_CHAN-1:0]    pullup_disable;
        logic [NUM_CHAN-1:0]    dir_force_input;
    } aic_pin_t;

endpackage : aic_pkg

// ==== tb_top.sv ====
// Self-checking testbench for the converter input select and control block.
// Assumes one AHB-Lite master, played here, and a zero-wait slave.
`timescale 1ns/10ps
module tb_top;
    logic              CLK_SYS = 1'b0;
    logic              RSTN, HSEL, HWRITE, HREADYOUT, HRESP, IRQ;
    logic [31:0]       HADDR, HWDATA, HRDATA, rd, last_res;
    logic [1:0]        HTRANS;
    logic [2:0]        HSIZE;
    logic [11:0]       DATA_IN;
    wire logic         HREADY = HREADYOUT;
    aic_pkg::aic_afe_t AFE;
    aic_pkg::aic_pin_t PIN_CTRL;
    int                error_cnt = 0;
    int                compares = 0;

    aic_ctrl u_aic_ctrl
    (
        .CLK_SYS, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
        .HREADY, .HRDATA, .HREADYOUT, .HRESP, .DATA_IN, .AFE, .PIN_CTRL, .IRQ
    );

    always #5 CLK_SYS = ~CLK_SYS;
    ////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // The master never assumes a latency; only HREADYOUT or this bound ends a wait.
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge CLK_SYS);
        while (HREADYOUT !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                chk("hready", 32'h1, 32'h0);
                test_done();
            end
            @(posedge CLK_SYS);
        end
    endtask : wait_rdy

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        HSEL   <= 1'b1;
        HADDR  <= {24'h0, a};
        HTRANS <= 2'h2;
        HWRITE <= w;
        wait_rdy();
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
        rd = HRDATA;
    endtask : xfer

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc

    task automatic count_active(output int n);
        n = 0;
        for (int t = 0; t < 3000 && !(n > 0 && (AFE.sample | AFE.convert) !== 1'b1); t++)
        begin
            @(posedge CLK_SYS);
            if ((AFE.sample | AFE.convert) === 1'b1)
                n++;
        end
    endtask : count_active
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int a = 0; a < 32; a += 4)
            rdc("reset value", a[7:0], 32'h0);
        xfer(1'b1, 8'h1c, 32'hffffffff);
        rdc("unmapped", 8'h1c, 32'h0);
        chk("irq reset", 32'h0, {31'h0, IRQ});
        $display("test reset done");
    endtask : t_reset

    task automatic t_pins;
        xfer(1'b1, aic_pkg::PINSEL_OFF, 32'ha5c3);
        repeat (2) @(posedge CLK_SYS);
        chk("digital off", 32'ha5c3, {16'h0, PIN_CTRL.digital_disable});
        chk("pullup off", 32'ha5c3, {16'h0, PIN_CTRL.pullup_disable});
        chk("dir override", 32'ha5c3, {16'h0, PIN_CTRL.dir_force_input});
        $display("test pins done");
    endtask : t_pins

    task automatic t_route;
        logic [3:0] s;
        int         e;
        for (int i = 0; i < 16; i++)
        begin
            s = i[3:0];
            e = (s == 0 || s == 4 || s >= 12) ? 0 : (s[3:2] == 2'b10) ? 7 : (s < 4) ? s : s - 1;
            xfer(1'b1, aic_pkg::CTRL1_OFF, {24'h0, s, 4'h0});
            xfer(1'b1, aic_pkg::CTRL0_OFF, {24'h0, 4'h2, s});
            repeat (2) @(posedge CLK_SYS);
            chk("source", e, {29'h0, AFE.source});
            chk("channel", e == 0 ? 32'h1 << s : 32'h0, {16'h0, AFE.chan_connect});
        end
        $display("test routing done");
    endtask : t_route

    task automatic t_conv(input int d);
        int          n;
        logic [11:0] v;
        logic        f;
        v = 12'h9c5 ^ {d[3:0], d[3:0], d[3:0]};
        f = d[0];
        xfer(1'b1, aic_pkg::INT_MASK_OFF, {31'h0, d[1]});
        DATA_IN <= v;
        xfer(1'b1, aic_pkg::CTRL1_OFF, {29'h0, d[2:0]});
        xfer(1'b1, aic_pkg::CTRL0_OFF, {24'h0, 3'h1, f, 4'h0});
        xfer(1'b1, aic_pkg::CTRL0_OFF, {24'h0, 3'h5, f, 4'h0});
        repeat (8) @(posedge CLK_SYS);
        chk("no start yet", 32'h0, {31'h0, AFE.sample});
        xfer(1'b1, aic_pkg::CTRL0_OFF, {24'h0, 3'h1, f, 4'h0});
        fork
            count_active(n);
            rdc("busy set", aic_pkg::CTRL0_OFF, {24'h0, 3'h3, f, 4'h0});
        join
        chk("conv cycles", 32'h10 << d, n);
        rdc("busy clear", aic_pkg::CTRL0_OFF, {24'h0, 3'h1, f, 4'h0});
        chk("irq level", {31'h0, d[1]}, {31'h0, IRQ});
        last_res = {20'h0, v};
        rdc("result", aic_pkg::RESULT_OFF, f ? last_res : last_res << 4);
        rdc("status set", aic_pkg::INT_STAT_OFF, 32'h1);
        rdc("status clear", aic_pkg::INT_STAT_OFF, 32'h0);
        chk("irq clear", 32'h0, {31'h0, IRQ});
        $display("test conversion div %0d done", d);
    endtask : t_conv

    task automatic t_off;
        int n;
        DATA_IN <= ~last_res[11:0];
        xfer(1'b1, aic_pkg::CTRL0_OFF, 32'h20);
        xfer(1'b1, aic_pkg::CTRL0_OFF, 32'ha0);
        xfer(1'b1, aic_pkg::CTRL0_OFF, 32'h20);
        rdc("abort busy", aic_pkg::CTRL0_OFF, 32'h60);
        // Clearing enable mid-conversion must abort without taking the new value.
        xfer(1'b1, aic_pkg::CTRL0_OFF, 32'h00);
        xfer(1'b1, aic_pkg::CTRL0_OFF, 32'h80);
        xfer(1'b1, aic_pkg::CTRL0_OFF, 32'h00);
        count_active(n);
        chk("off activity", 32'h0, n);
        rdc("off busy", aic_pkg::CTRL0_OFF, 32'h0);
        chk("power off", 32'h0, {31'h0, AFE.conv_power});
        rdc("result kept", aic_pkg::RESULT_OFF, last_res << 4);
        $display("test disabled done");
    endtask : t_off
    ////////////////////////////////////////////////////////////////
    initial
    begin
        RSTN = 1'b0;
        HSEL = 1'b0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
        DATA_IN = 12'h0;
        last_res = 32'h0;
        repeat (3) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        t_reset();
        t_pins();
        t_route();
        for (int d = 0; d < 7; d++)
            t_conv(d);
        // The slowest divider gives 1.28 us here, inside both recommended ranges.
        t_conv(7);
        t_off();
        test_done();
    end
endmodule : tb_top
